// ===== rpsm_far_model.sv
/*
  Far side of the pin map: remappable pin levels and peripheral outputs.
  Assumes the bench sets both patterns; they move only after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rpsm_far_model (
  input  wire logic        mclk,
  input  wire logic [63:0] pin_level,
  input  wire logic [63:0] func_level,
  output var  logic [63:0] remappable_pin,
  output var  logic [63:0] periph_func_out
);
  // peripherals share mclk, so their outputs change just after an edge
  always_ff @(posedge mclk)
  begin
    remappable_pin  <= pin_level;
    periph_func_out <= func_level;
  end
endmodule : rpsm_far_model
`default_nettype wire

// ===== rpsm_pkg.sv
/*
  Constants for the remappable pin select map: register indices, field
  positions, field width and power-on values of the selectors.
  Assumes a 16-bit register port with a 4-bit word address.
*/
`default_nettype none

package rpsm_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned SEL_W    = 6;
  localparam int unsigned N_IN     = 8;
  localparam int unsigned N_OUTPIN = 8;

  // register indices
  localparam logic [3:0] SPI2_CLOCK_DATA_INPUT_SELECT   = 4'h0;
  localparam logic [3:0] SPI2_SLAVE_SELECT_INPUT_SELECT = 4'h1;
  localparam logic [3:0] UART4_INPUT_SELECT             = 4'h2;
  localparam logic [3:0] SPI3_CLOCK_DATA_INPUT_SELECT   = 4'h3;
  localparam logic [3:0] SPI3_SLAVE_SELECT_INPUT_SELECT = 4'h4;
  localparam logic [3:0] PINS_0_1_OUTPUT_FUNCTION       = 4'h5;
  localparam logic [3:0] PINS_2_3_OUTPUT_FUNCTION       = 4'h6;
  localparam logic [3:0] PINS_4_5_OUTPUT_FUNCTION       = 4'h7;
  localparam logic [3:0] PINS_6_7_OUTPUT_FUNCTION       = 4'h8;

  // field positions inside a selector word
  localparam int unsigned LO_FIELD_LSB = 0;
  localparam int unsigned HI_FIELD_LSB = 8;

  // input fields, in order: port2 clock, port2 data, port2 select,
  // uart4 cts, uart4 rx, port3 clock, port3 data, port3 select
  localparam logic [3:0] IN_REG [N_IN] = '{
    SPI2_CLOCK_DATA_INPUT_SELECT, SPI2_CLOCK_DATA_INPUT_SELECT,
    SPI2_SLAVE_SELECT_INPUT_SELECT, UART4_INPUT_SELECT,
    UART4_INPUT_SELECT, SPI3_CLOCK_DATA_INPUT_SELECT,
    SPI3_CLOCK_DATA_INPUT_SELECT, SPI3_SLAVE_SELECT_INPUT_SELECT};
  localparam int unsigned IN_LSB [N_IN] = '{
    HI_FIELD_LSB, LO_FIELD_LSB, LO_FIELD_LSB, HI_FIELD_LSB,
    LO_FIELD_LSB, HI_FIELD_LSB, LO_FIELD_LSB, LO_FIELD_LSB};

  // output pin 2k and 2k+1 live in register OUT_REG_BASE + k
  localparam logic [3:0] OUT_REG_BASE = PINS_0_1_OUTPUT_FUNCTION;
  localparam int unsigned NARROW_PKG_GAP_PIN = 5;

  localparam logic [5:0] IN_SEL_RST  = 6'h3F;
  localparam logic [5:0] OUT_SEL_RST = 6'h00;
  localparam logic [5:0] FUNC_NONE   = 6'h00;

endpackage : rpsm_pkg

`default_nettype wire

// ===== rpsm_test.sv
/*
  Self-checking bench for the pin map: register table, routing, reset.
  Assumes rpsm_top with 64 pins and 64 functions, full package plus a narrow package twin.
*/
`timescale 1ns/100ps
`default_nettype none
module rpsm_test;
  localparam logic [63:0] PINS  = 64'h8000_0000_0000_00F0;
  localparam logic [63:0] FUNCS = 64'h8000_0000_0000_0423;
  // rows: address, written word, word read back
  localparam logic [35:0] ROWS [10] = '{
    36'h0_C401_0401, 36'h1_FFFF_003F, 36'h2_C582_0502, 36'h3_86C3_0603,
    36'h4_FFC7_0007, 36'h5_C1C0_0100, 36'h6_FFC2_3F02, 36'h7_0B0A_0B0A,
    36'h8_45E0_0520, 36'h9_FFFF_0000};
  logic        mclk       = 1'b0;
  logic        reset      = 1'b1;
  logic [3:0]  reg_addr   = 4'h0;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [63:0] pin_level  = 64'h0000_0000_0000_0000;
  logic [63:0] func_level = 64'h0000_0000_0000_0000;
  logic [15:0] reg_rdata;
  logic [15:0] rdata_narrow;
  logic [63:0] pins;
  logic [63:0] funcs;
  logic [7:0]  routed;
  logic [7:0]  pin_out;
  logic [7:0]  mapped;
  logic [15:0] exp_word;
  int          n_fail     = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;

  always #4 mclk = ~mclk;

  rpsm_far_model u_far (.mclk(mclk), .pin_level(pin_level),
    .func_level(func_level), .remappable_pin(pins),
    .periph_func_out(funcs));

  rpsm_top #(.N_PINS(64), .N_FUNCS(64), .NARROW_PKG(1'b0)) u_dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .remappable_pin(pins), .periph_func_out(funcs),
    .port2_clock_input(routed[0]), .port2_data_input(routed[1]),
    .port2_select_input(routed[2]), .uart_four_cts_input(routed[3]),
    .uart_four_rx_input(routed[4]), .port3_clock_input(routed[5]),
    .port3_data_input(routed[6]), .port3_select_input(routed[7]),
    .remappable_pin_out(pin_out), .remappable_pin_mapped(mapped));

  // narrow package twin on the same bus: only its read data is watched
  rpsm_top #(.N_PINS(64), .N_FUNCS(64), .NARROW_PKG(1'b1)) u_dut_narrow (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_narrow), .remappable_pin(pins),
    .periph_func_out(funcs), .port2_clock_input(), .port2_data_input(),
    .port2_select_input(), .uart_four_cts_input(), .uart_four_rx_input(),
    .port3_clock_input(), .port3_data_input(), .port3_select_input(),
    .remappable_pin_out(), .remappable_pin_mapped());

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one idle cycle after each strobe keeps a strobe from being set twice
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
    check("narrow_rdata", (a == 4'h7) ? (exp & 16'h00FF) : exp, rdata_narrow);
    @(posedge mclk);
  endtask : rd_chk

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      exp_word = (i == 1 || i == 4) ? 16'h003F : 16'h3F3F;
      exp_word = (i > 4) ? 16'h0000 : exp_word;
      rd_chk(4'(i), exp_word);
    end
    for (int i = 0; i < 10; i++)
    begin
      wr_reg(ROWS[i][35:32], ROWS[i][31:16]);
      rd_chk(ROWS[i][35:32], ROWS[i][15:0]);
    end
    // the inverse pattern proves each routed input and pin outputs 1 to 7 follow their source, not a constant; pin 0 has code 0 and stays low
    for (int k = 0; k < 2; k++)
    begin
      pin_level  <= k ? ~PINS : PINS;
      func_level <= k ? ~FUNCS : FUNCS;
      repeat (6) @(posedge mclk);
      #1;
      check("routed", {8'h00, k ? 8'h52 : 8'hAD}, {8'h00, routed});
      check("pin_out", {8'h00, k ? 8'h64 : 8'h9A}, {8'h00, pin_out});
      check("mapped", 16'h00FE, {8'h00, mapped});
      @(posedge mclk);
    end
    wr_reg(4'h0, 16'h0104);
    @(posedge mclk);
    #1;
    check("routed", 16'h0051, {8'h00, routed});
    // write then read with no gap between the strobes
    reg_addr  <= 4'h2;
    reg_wdata <= 16'hD2F4;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    #1;
    check("readback", 16'h1234, reg_rdata);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    #1;
    check("outputs", 16'h0000, {routed, pin_out | mapped});
    reset <= 1'b0;
    @(posedge mclk);
    rd_chk(4'h0, 16'h3F3F);
    rd_chk(4'h8, 16'h0000);
    finish_test();
  end
endmodule : rpsm_test
`default_nettype wire

// ===== rpsm_top.sv
/*
  Remappable pin select map: eight input selectors steering remappable
  pins onto serial port and uart inputs, eight output selectors putting
  peripheral output functions onto remappable pins 0 to 7.
  Assumes pins arrive asynchronously; peripheral outputs share mclk.
*/
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - port2 clock input follows pin chosen by bits 13-8 of selector 0.
// - port2 data input follows pin chosen by bits 5-0 of selector 0.
// - port2 select input follows bits 5-0 of selector 1; rest unused.
// - uart4 cts input follows pin chosen by bits 13-8 of selector 2.
// - uart4 rx input follows pin chosen by bits 5-0 of selector 2.
// - port3 clock input follows pin chosen by bits 13-8 of selector 3.
// - port3 data input follows pin chosen by bits 5-0 of selector 3.
// - port3 select input follows bits 5-0 of selector 4; rest unused.
// - each output pin carries the peripheral function numbered by its field; code 0 or a code past the last function drives low.
// - output word 5 holds pin 0 in bits 5-0, pin 1 in 13-8.
// - output word 6 holds pin 2 in bits 5-0, pin 3 in 13-8.
// - output word 7 holds pin 4 in bits 5-0, pin 5 in 13-8.
// - output word 8 holds pin 6 in bits 5-0, pin 7 in 13-8.
// - unimplemented bits ignore writes and read zero.
// - narrow package: pin 5 field absent, reads zero.
// - reset sets input fields to ones, output fields to zero.
module rpsm_top #(
  parameter int unsigned N_PINS      = 64,
  parameter int unsigned N_FUNCS     = 64,
  parameter bit          NARROW_PKG  = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [15:0]           reg_rdata,
  input  wire logic [N_PINS-1:0]     remappable_pin,
  input  wire logic [N_FUNCS-1:0]    periph_func_out,
  output var  logic                  port2_clock_input,
  output var  logic                  port2_data_input,
  output var  logic                  port2_select_input,
  output var  logic                  uart_four_cts_input,
  output var  logic                  uart_four_rx_input,
  output var  logic                  port3_clock_input,
  output var  logic                  port3_data_input,
  output var  logic                  port3_select_input,
  output var  logic [7:0]            remappable_pin_out,
  output var  logic [7:0]            remappable_pin_mapped
);

  initial
  begin
    if (N_PINS < 1 || N_PINS > 64)
      $error("N_PINS must lie in 1..64");
    if (N_FUNCS < 1 || N_FUNCS > 64)
      $error("N_FUNCS must lie in 1..64");
  end

  logic [5:0]        in_sel  [rpsm_pkg::N_IN];
  logic [5:0]        out_sel [rpsm_pkg::N_OUTPIN];
  logic [N_PINS-1:0] pin_meta;
  logic [N_PINS-1:0] pin_sync;
  logic [7:0]        routed_in;
  logic [15:0]       next_rdata;

  // a selector past the last pin yields a quiet low rather than x
  function automatic logic pick_pin(input logic [5:0]        sel,
                                    input logic [N_PINS-1:0] pins);
    logic r;
    r = 1'b0;
    if (32'(sel) < N_PINS)
      r = pins[sel];
    return r;
  endfunction : pick_pin

  function automatic logic pick_func(input logic [5:0]         code,
                                     input logic [N_FUNCS-1:0] funcs);
    logic r;
    r = 1'b0;
    if (code != rpsm_pkg::FUNC_NONE && 32'(code) < N_FUNCS)
      r = funcs[code];
    return r;
  endfunction : pick_func

  // pins are asynchronous; only pin_sync is looked at
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= remappable_pin;
      pin_sync <= pin_meta;
    end
  end

  genvar gi;

  // input selectors and their routing
  generate
    for (gi = 0; gi < rpsm_pkg::N_IN; gi++)
    begin : g_in
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          in_sel[gi] <= rpsm_pkg::IN_SEL_RST;
        else if (reg_wr && reg_addr == rpsm_pkg::IN_REG[gi])
          in_sel[gi] <= reg_wdata[rpsm_pkg::IN_LSB[gi] +: 6];
      end

      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          routed_in[gi] <= 1'b0;
        else
          routed_in[gi] <= pick_pin(in_sel[gi], pin_sync);
      end

      AST_IN_ROUTE: assert property (@(posedge mclk) disable iff (reset)
        routed_in[gi] == $past(pick_pin(in_sel[gi], pin_sync)))
        else $error("input route does not follow its selector");

      AST_IN_WRITE: assert property (@(posedge mclk) disable iff (reset)
        (reg_wr && reg_addr == rpsm_pkg::IN_REG[gi])
        |=> in_sel[gi] == $past(reg_wdata[rpsm_pkg::IN_LSB[gi] +: 6]))
        else $error("input selector did not take the write");

      // a selector must not drift between writes, or routing glitches
      AST_IN_HOLD: assert property (@(posedge mclk) disable iff (reset)
        !(reg_wr && reg_addr == rpsm_pkg::IN_REG[gi])
        |=> $stable(in_sel[gi]))
        else $error("input selector changed without a write");

      AST_IN_RESET: assert property (@(posedge mclk)
        $fell(reset) |-> in_sel[gi] == rpsm_pkg::IN_SEL_RST)
        else $error("input selector not at its power-on value");
    end
  endgenerate

  assign port2_clock_input   = routed_in[0];
  assign port2_data_input    = routed_in[1];
  assign port2_select_input  = routed_in[2];
  assign uart_four_cts_input = routed_in[3];
  assign uart_four_rx_input  = routed_in[4];
  assign port3_clock_input   = routed_in[5];
  assign port3_data_input    = routed_in[6];
  assign port3_select_input  = routed_in[7];

  // output selectors, two pins per word, even pin in the low field
  generate
    for (gi = 0; gi < rpsm_pkg::N_OUTPIN; gi++)
    begin : g_out
      localparam logic [3:0] WREG =
        4'(rpsm_pkg::OUT_REG_BASE + gi / 2);
      localparam int unsigned WLSB = (gi % 2 == 0) ?
        rpsm_pkg::LO_FIELD_LSB : rpsm_pkg::HI_FIELD_LSB;
      localparam bit ABSENT =
        NARROW_PKG && gi == rpsm_pkg::NARROW_PKG_GAP_PIN;

      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          out_sel[gi] <= rpsm_pkg::OUT_SEL_RST;
        else if (reg_wr && reg_addr == WREG && !ABSENT)
          out_sel[gi] <= reg_wdata[WLSB +: 6];
      end

      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          remappable_pin_out[gi]    <= 1'b0;
          remappable_pin_mapped[gi] <= 1'b0;
        end
        else
        begin
          remappable_pin_out[gi]    <= pick_func(out_sel[gi],
                                                 periph_func_out);
          remappable_pin_mapped[gi] <= out_sel[gi] != rpsm_pkg::FUNC_NONE;
        end
      end

      AST_OUT_ROUTE: assert property (@(posedge mclk) disable iff (reset)
        remappable_pin_out[gi] ==
          $past(pick_func(out_sel[gi], periph_func_out)))
        else $error("pin output does not follow its function code");

      AST_OUT_FIELD: assert property (@(posedge mclk) disable iff (reset)
        (reg_wr && reg_addr == WREG && !ABSENT)
        ##1 (!reg_wr || reg_addr != WREG)
        |-> ##1 remappable_pin_mapped[gi] ==
          ($past(reg_wdata[WLSB +: 6], 2) != rpsm_pkg::FUNC_NONE))
        else $error("pin mapping ignores its field position");

      AST_OUT_WRITE: assert property (@(posedge mclk) disable iff (reset)
        (reg_wr && reg_addr == WREG && !ABSENT)
        |=> out_sel[gi] == $past(reg_wdata[WLSB +: 6]))
        else $error("output selector did not take the write");

      AST_OUT_HOLD: assert property (@(posedge mclk) disable iff (reset)
        !(reg_wr && reg_addr == WREG)
        |=> $stable(out_sel[gi]))
        else $error("output selector changed without a write");

      AST_OUT_MAPPED: assert property (@(posedge mclk) disable iff (reset)
        remappable_pin_mapped[gi] ==
          $past(out_sel[gi] != rpsm_pkg::FUNC_NONE))
        else $error("mapped flag does not follow its function code");

      AST_OUT_RESET: assert property (@(posedge mclk)
        $fell(reset) |-> out_sel[gi] == rpsm_pkg::OUT_SEL_RST)
        else $error("output selector not at its power-on value");

      // the absent field must stay at zero whatever software writes
      AST_OUT_ABSENT: assert property (@(posedge mclk) disable iff (reset)
        ABSENT |-> out_sel[gi] == rpsm_pkg::FUNC_NONE)
        else $error("absent pin field holds a code");
    end
  endgenerate

  // read mux; holes and unmapped words read zero
  always_comb
  begin
    next_rdata = '0;
    for (int i = 0; i < rpsm_pkg::N_IN; i++)
      if (reg_addr == rpsm_pkg::IN_REG[i])
        next_rdata[rpsm_pkg::IN_LSB[i] +: 6] = in_sel[i];
    for (int j = 0; j < rpsm_pkg::N_OUTPIN; j++)
      if (reg_addr == 4'(rpsm_pkg::OUT_REG_BASE + j / 2))
        next_rdata[(j % 2) * 8 +: 6] = out_sel[j];
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= '0;
  end

  AST_UNUSED_BITS: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) |-> reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
    else $error("unimplemented bits read nonzero");

  AST_SS_UPPER: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) && ($past(reg_addr) ==
      rpsm_pkg::SPI2_SLAVE_SELECT_INPUT_SELECT || $past(reg_addr) ==
      rpsm_pkg::SPI3_SLAVE_SELECT_INPUT_SELECT)
    |-> reg_rdata[15:6] == 10'h000)
    else $error("select-only word shows upper bits");

  AST_PIN5_ABSENT: assert property (@(posedge mclk) disable iff (reset)
    NARROW_PKG && $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::PINS_4_5_OUTPUT_FUNCTION
    |-> reg_rdata[13:8] == 6'h00)
    else $error("absent pin 5 field reads nonzero");

  AST_READBACK: assert property (@(posedge mclk) disable iff (reset)
    reg_wr && reg_addr == rpsm_pkg::UART4_INPUT_SELECT
    ##1 reg_rd && reg_addr == rpsm_pkg::UART4_INPUT_SELECT
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h3F3F))
    else $error("uart4 selector readback differs from write");

  AST_RESET_VALUE: assert property (@(posedge mclk)
    $fell(reset) |-> in_sel[0] == 6'h3F && out_sel[0] == 6'h00)
    else $error("selectors not at power-on values");

  // the data strobe is a single cycle; a lingering word would look valid
  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (reset)
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data present without a read strobe");

  // each routed peripheral input, by name
  AST_PORT2_CLOCK: assert property (@(posedge mclk) disable iff (reset)
    port2_clock_input == $past(pick_pin(in_sel[0], pin_sync)))
    else $error("port2 clock input follows the wrong pin");

  AST_PORT2_DATA: assert property (@(posedge mclk) disable iff (reset)
    port2_data_input == $past(pick_pin(in_sel[1], pin_sync)))
    else $error("port2 data input follows the wrong pin");

  AST_PORT2_SELECT: assert property (@(posedge mclk) disable iff (reset)
    port2_select_input == $past(pick_pin(in_sel[2], pin_sync)))
    else $error("port2 select input follows the wrong pin");

  AST_UART_CTS: assert property (@(posedge mclk) disable iff (reset)
    uart_four_cts_input == $past(pick_pin(in_sel[3], pin_sync)))
    else $error("uart4 cts input follows the wrong pin");

  AST_UART_RX: assert property (@(posedge mclk) disable iff (reset)
    uart_four_rx_input == $past(pick_pin(in_sel[4], pin_sync)))
    else $error("uart4 rx input follows the wrong pin");

  AST_PORT3_CLOCK: assert property (@(posedge mclk) disable iff (reset)
    port3_clock_input == $past(pick_pin(in_sel[5], pin_sync)))
    else $error("port3 clock input follows the wrong pin");

  AST_PORT3_DATA: assert property (@(posedge mclk) disable iff (reset)
    port3_data_input == $past(pick_pin(in_sel[6], pin_sync)))
    else $error("port3 data input follows the wrong pin");

  AST_PORT3_SELECT: assert property (@(posedge mclk) disable iff (reset)
    port3_select_input == $past(pick_pin(in_sel[7], pin_sync)))
    else $error("port3 select input follows the wrong pin");

  // readback of every word against the selectors it packs
  AST_WORD0_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::SPI2_CLOCK_DATA_INPUT_SELECT
    |-> reg_rdata == $past({2'h0, in_sel[0], 2'h0, in_sel[1]}))
    else $error("port2 clock/data word reads wrong");

  AST_WORD1_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::SPI2_SLAVE_SELECT_INPUT_SELECT
    |-> reg_rdata == $past({10'h000, in_sel[2]}))
    else $error("port2 select word reads wrong");

  AST_WORD2_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::UART4_INPUT_SELECT
    |-> reg_rdata == $past({2'h0, in_sel[3], 2'h0, in_sel[4]}))
    else $error("uart4 word reads wrong");

  AST_WORD3_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::SPI3_CLOCK_DATA_INPUT_SELECT
    |-> reg_rdata == $past({2'h0, in_sel[5], 2'h0, in_sel[6]}))
    else $error("port3 clock/data word reads wrong");

  AST_WORD4_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::SPI3_SLAVE_SELECT_INPUT_SELECT
    |-> reg_rdata == $past({10'h000, in_sel[7]}))
    else $error("port3 select word reads wrong");

  AST_WORD5_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::PINS_0_1_OUTPUT_FUNCTION
    |-> reg_rdata == $past({2'h0, out_sel[1], 2'h0, out_sel[0]}))
    else $error("pins 0/1 word reads wrong");

  AST_WORD6_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::PINS_2_3_OUTPUT_FUNCTION
    |-> reg_rdata == $past({2'h0, out_sel[3], 2'h0, out_sel[2]}))
    else $error("pins 2/3 word reads wrong");

  AST_WORD7_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::PINS_4_5_OUTPUT_FUNCTION
    |-> reg_rdata == $past({2'h0, out_sel[5], 2'h0, out_sel[4]}))
    else $error("pins 4/5 word reads wrong");

  AST_WORD8_READ: assert property (@(posedge mclk) disable iff (reset)
    $past(reg_rd) &&
    $past(reg_addr) == rpsm_pkg::PINS_6_7_OUTPUT_FUNCTION
    |-> reg_rdata == $past({2'h0, out_sel[7], 2'h0, out_sel[6]}))
    else $error("pins 6/7 word reads wrong");

endmodule : rpsm_top

`default_nettype wire
